// file: rtl/odg_pkg.sv
package odg_pkg;

	// Register offsets on page 1 (byte addresses of the control port)
	localparam logic [7:0] ODG_HP_VOL_ADDR      = 8'h24;
	localparam logic [7:0] ODG_HP_VOL_RSVD_ADDR = 8'h25;
	localparam logic [7:0] ODG_SP_VOL_ADDR      = 8'h26;
	localparam logic [7:0] ODG_SP_VOL_RSVD_ADDR = 8'h27;
	localparam logic [7:0] ODG_HP_DRV_ADDR      = 8'h28;
	localparam logic [7:0] ODG_HP_DRV_RSVD_ADDR = 8'h29;
	localparam logic [7:0] ODG_SP_DRV_ADDR      = 8'h2A;
	localparam logic [7:0] ODG_SP_DRV_RSVD_ADDR = 8'h2B;

	// Field positions
	localparam int ODG_ROUTE_BIT    = 7;
	localparam int ODG_ATTEN_MSB    = 6;
	localparam int ODG_HP_GAIN_MSB  = 6;
	localparam int ODG_HP_GAIN_LSB  = 3;
	localparam int ODG_SP_GAIN_MSB  = 4;
	localparam int ODG_SP_GAIN_LSB  = 3;
	localparam int ODG_UNMUTE_BIT   = 2;
	localparam int ODG_HIZ_BIT      = 1;
	localparam int ODG_APPLIED_BIT  = 0;

	// Reset values, plus the top headphone gain code
	localparam logic       ODG_ROUTE_RST   = 1'h0;
	localparam logic [6:0] ODG_ATTEN_RST   = 7'h7F;
	localparam logic [3:0] ODG_HP_GAIN_RST = 4'h0;
	localparam logic [3:0] ODG_HP_GAIN_MAX = 4'h9;
	localparam logic [1:0] ODG_SP_GAIN_RST = 2'h0;
	localparam logic       ODG_UNMUTE_RST  = 1'h0;
	localparam logic       ODG_HIZ_RST     = 1'h1;
	localparam logic [7:0] ODG_VOL_RSVD_RST = 8'h7F;

	// Time for a newly written gain to settle in the analog stage
	localparam int ODG_SETTLE_NS     = 1000;
	localparam int ODG_CLK_PERIOD_NS = 40;
	localparam int ODG_SETTLE_CYCLES =
		(ODG_SETTLE_NS + ODG_CLK_PERIOD_NS - 1) / ODG_CLK_PERIOD_NS;
	localparam int ODG_CNT_W = 6;

endpackage : odg_pkg

// file: rtl/odg_output_driver_gain_regs.sv
`timescale 1ns/1ps
module odg_output_driver_gain_regs
	import odg_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       rst_n,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata,
	output logic            hp_route_en,
	output logic      [6:0] hp_atten,
	output logic      [3:0] hp_drv_gain,
	output logic            hp_unmute,
	output logic            hp_pd_hiz,
	output logic            hp_gain_applied,
	output logic            sp_route_en,
	output logic      [6:0] sp_atten,
	output logic      [1:0] sp_drv_gain,
	output logic            sp_unmute,
	output logic            sp_gain_applied
);

	typedef enum logic {
		ODG_IDLE,
		ODG_SETTLING
	} odg_settle_type;

	// Write selects, one per register that holds state
	logic       wr_hp_vol;
	logic       wr_sp_vol;
	logic       wr_hp_drv;
	logic       wr_sp_drv;

	logic       hp_route_reg,  hp_route_next;
	logic [6:0] hp_atten_reg,  hp_atten_next;
	logic       sp_route_reg,  sp_route_next;
	logic [6:0] sp_atten_reg,  sp_atten_next;
	logic [3:0] hp_gain_reg,   hp_gain_next;
	logic       hp_unmute_reg, hp_unmute_next;
	logic       hp_hiz_reg,    hp_hiz_next;
	logic [1:0] sp_gain_reg,   sp_gain_next;
	logic       sp_unmute_reg, sp_unmute_next;
	logic [7:0] rdata_reg,     rdata_next;

	logic [1:0] gain_wr;
	logic [1:0] applied;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		hit = (a == o);
	endfunction : hit

	// Volume registers share one layout: route bit above the attenuation
	function automatic logic [7:0] vol_word(
		input logic       route,
		input logic [6:0] atten
	);
		vol_word                  = 8'h00;
		vol_word[ODG_ROUTE_BIT]   = route;
		vol_word[ODG_ATTEN_MSB:0] = atten;
	endfunction : vol_word

	// Headphone driver word; reserved bit 7 reads as zero
	function automatic logic [7:0] hp_drv_word(
		input logic [3:0] gain,
		input logic       unmute,
		input logic       hiz,
		input logic       done
	);
		hp_drv_word = 8'h00;
		hp_drv_word[ODG_HP_GAIN_MSB:ODG_HP_GAIN_LSB] = gain;
		hp_drv_word[ODG_UNMUTE_BIT]                  = unmute;
		hp_drv_word[ODG_HIZ_BIT]                     = hiz;
		hp_drv_word[ODG_APPLIED_BIT]                 = done;
	endfunction : hp_drv_word

	// Class-D driver word; reserved bits 7..5 and 1 read as zero
	function automatic logic [7:0] sp_drv_word(
		input logic [1:0] gain,
		input logic       unmute,
		input logic       done
	);
		sp_drv_word = 8'h00;
		sp_drv_word[ODG_SP_GAIN_MSB:ODG_SP_GAIN_LSB] = gain;
		sp_drv_word[ODG_UNMUTE_BIT]                  = unmute;
		sp_drv_word[ODG_APPLIED_BIT]                 = done;
	endfunction : sp_drv_word

	// Reserved registers have no select, so writes to them are dropped
	assign wr_hp_vol = reg_wr && hit(reg_addr, ODG_HP_VOL_ADDR);
	assign wr_sp_vol = reg_wr && hit(reg_addr, ODG_SP_VOL_ADDR);
	assign wr_hp_drv = reg_wr && hit(reg_addr, ODG_HP_DRV_ADDR);
	assign wr_sp_drv = reg_wr && hit(reg_addr, ODG_SP_DRV_ADDR);

	// Any write to a path's volume or gain register restarts its settling
	assign gain_wr[0] = wr_hp_vol || wr_hp_drv;
	assign gain_wr[1] = wr_sp_vol || wr_sp_drv;

	// Headphone volume register
	always_comb begin
		hp_route_next = hp_route_reg;
		hp_atten_next = hp_atten_reg;
		if (wr_hp_vol) begin
			hp_route_next = reg_wdata[ODG_ROUTE_BIT];
			hp_atten_next = reg_wdata[ODG_ATTEN_MSB:0];
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			hp_route_reg <= ODG_ROUTE_RST;
			hp_atten_reg <= ODG_ATTEN_RST;
		end else begin
			hp_route_reg <= hp_route_next;
			hp_atten_reg <= hp_atten_next;
		end
	end

	// Speaker volume register
	always_comb begin
		sp_route_next = sp_route_reg;
		sp_atten_next = sp_atten_reg;
		if (wr_sp_vol) begin
			sp_route_next = reg_wdata[ODG_ROUTE_BIT];
			sp_atten_next = reg_wdata[ODG_ATTEN_MSB:0];
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			sp_route_reg <= ODG_ROUTE_RST;
			sp_atten_reg <= ODG_ATTEN_RST;
		end else begin
			sp_route_reg <= sp_route_next;
			sp_atten_reg <= sp_atten_next;
		end
	end

	// Headphone driver register; codes above 9 are stored as written
	always_comb begin
		hp_gain_next   = hp_gain_reg;
		hp_unmute_next = hp_unmute_reg;
		hp_hiz_next    = hp_hiz_reg;
		if (wr_hp_drv) begin
			hp_gain_next =
				reg_wdata[ODG_HP_GAIN_MSB:ODG_HP_GAIN_LSB];
			hp_unmute_next = reg_wdata[ODG_UNMUTE_BIT];
			hp_hiz_next    = reg_wdata[ODG_HIZ_BIT];
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			hp_gain_reg   <= ODG_HP_GAIN_RST;
			hp_unmute_reg <= ODG_UNMUTE_RST;
			hp_hiz_reg    <= ODG_HIZ_RST;
		end else begin
			hp_gain_reg   <= hp_gain_next;
			hp_unmute_reg <= hp_unmute_next;
			hp_hiz_reg    <= hp_hiz_next;
		end
	end

	// Class-D driver register
	always_comb begin
		sp_gain_next   = sp_gain_reg;
		sp_unmute_next = sp_unmute_reg;
		if (wr_sp_drv) begin
			sp_gain_next =
				reg_wdata[ODG_SP_GAIN_MSB:ODG_SP_GAIN_LSB];
			sp_unmute_next = reg_wdata[ODG_UNMUTE_BIT];
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			sp_gain_reg   <= ODG_SP_GAIN_RST;
			sp_unmute_reg <= ODG_UNMUTE_RST;
		end else begin
			sp_gain_reg   <= sp_gain_next;
			sp_unmute_reg <= sp_unmute_next;
		end
	end

	// One settling tracker per path: 0 is headphone, 1 is speaker
	genvar p;
	generate
		for (p = 0; p < 2; p++) begin : g_settle
			odg_settle_type       st_reg;
			odg_settle_type       st_next;
			logic [ODG_CNT_W-1:0] cnt_reg;
			logic [ODG_CNT_W-1:0] cnt_next;

			// Flag is low from the edge after a write until the count ends
			always_comb begin
				st_next  = st_reg;
				cnt_next = cnt_reg;
				case (st_reg)
					ODG_IDLE: begin
						if (gain_wr[p]) begin
							st_next  = ODG_SETTLING;
							cnt_next = ODG_CNT_W'(ODG_SETTLE_CYCLES - 1);
						end
					end
					ODG_SETTLING: begin
						if (gain_wr[p]) begin
							// A rewrite mid-settle starts the wait over
							cnt_next = ODG_CNT_W'(ODG_SETTLE_CYCLES - 1);
						end else if (cnt_reg == '0) begin
							st_next = ODG_IDLE;
						end else begin
							cnt_next = cnt_reg - 1'b1;
						end
					end
					default: begin
						st_next  = ODG_IDLE;
						cnt_next = '0;
					end
				endcase
			end

			always_ff @(posedge mclk) begin
				if (!rst_n) begin
					st_reg  <= ODG_IDLE;
					cnt_reg <= '0;
				end else begin
					st_reg  <= st_next;
					cnt_reg <= cnt_next;
				end
			end

			assign applied[p] = (st_reg == ODG_IDLE);
		end
	endgenerate

	// A read in the same cycle as a write returns the old value
	always_comb begin
		rdata_next = rdata_reg;
		if (reg_rd) begin
			case (reg_addr)
				ODG_HP_VOL_ADDR: begin
					rdata_next = vol_word(hp_route_reg, hp_atten_reg);
				end
				ODG_SP_VOL_ADDR: begin
					rdata_next = vol_word(sp_route_reg, sp_atten_reg);
				end
				ODG_HP_VOL_RSVD_ADDR, ODG_SP_VOL_RSVD_ADDR: begin
					rdata_next = ODG_VOL_RSVD_RST;
				end
				ODG_HP_DRV_ADDR: begin
					rdata_next = hp_drv_word(hp_gain_reg, hp_unmute_reg,
						hp_hiz_reg, applied[0]);
				end
				ODG_SP_DRV_ADDR: begin
					rdata_next = sp_drv_word(sp_gain_reg, sp_unmute_reg,
						applied[1]);
				end
				// Reserved driver registers hold nothing and read as zero
				ODG_HP_DRV_RSVD_ADDR, ODG_SP_DRV_RSVD_ADDR: begin
					rdata_next = 8'h00;
				end
				default: begin
					rdata_next = 8'h00;
				end
			endcase
		end
	end

	// Read data holds until the next read
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			rdata_reg <= 8'h00;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	assign reg_rdata       = rdata_reg;
	assign hp_route_en     = hp_route_reg;
	assign hp_atten        = hp_atten_reg;
	assign hp_drv_gain     = hp_gain_reg;
	assign hp_unmute       = hp_unmute_reg;
	assign hp_pd_hiz       = hp_hiz_reg;
	assign hp_gain_applied = applied[0];
	assign sp_route_en     = sp_route_reg;
	assign sp_atten        = sp_atten_reg;
	assign sp_drv_gain     = sp_gain_reg;
	assign sp_unmute       = sp_unmute_reg;
	assign sp_gain_applied = applied[1];

endmodule : odg_output_driver_gain_regs

// file: verification/odg_checker.sv
`timescale 1ns/1ps
module odg_checker
	import odg_pkg::*;
(
	input wire logic       mclk,
	input wire logic       rst_n,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic       hp_route_en,
	input wire logic [6:0] hp_atten,
	input wire logic [3:0] hp_drv_gain,
	input wire logic       hp_unmute,
	input wire logic       hp_pd_hiz,
	input wire logic       hp_gain_applied,
	input wire logic       sp_route_en,
	input wire logic [6:0] sp_atten,
	input wire logic [1:0] sp_drv_gain,
	input wire logic       sp_unmute,
	input wire logic       sp_gain_applied
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	logic [4:0] hp_cnt;
	logic [4:0] sp_cnt;
	wire hp_w = reg_wr && reg_addr inside {ODG_HP_VOL_ADDR, ODG_HP_DRV_ADDR};
	wire sp_w = reg_wr && reg_addr inside {ODG_SP_VOL_ADDR, ODG_SP_DRV_ADDR};
	// Cycles since the last gain write on each path, saturating
	always_ff @(posedge mclk) begin
		hp_cnt <= !rst_n ? 5'h1F : hp_w ? 5'h00 : hp_cnt + 5'(hp_cnt != 5'h1F);
		sp_cnt <= !rst_n ? 5'h1F : sp_w ? 5'h00 : sp_cnt + 5'(sp_cnt != 5'h1F);
	end
	sequence hp_drv_rd;
		reg_rd && reg_addr == ODG_HP_DRV_ADDR;
	endsequence
	hp_vol_a: assert property (reg_wr && reg_addr == ODG_HP_VOL_ADDR
		|=> {hp_route_en, hp_atten} == $past(reg_wdata)) else $error("hp volume");
	sp_vol_a: assert property (reg_wr && reg_addr == ODG_SP_VOL_ADDR
		|=> {sp_route_en, sp_atten} == $past(reg_wdata)) else $error("sp volume");
	hp_drv_a: assert property (reg_wr && reg_addr == ODG_HP_DRV_ADDR
		|=> {hp_drv_gain, hp_unmute, hp_pd_hiz} == $past(reg_wdata[6:1]))
		else $error("hp driver");
	sp_drv_a: assert property (reg_wr && reg_addr == ODG_SP_DRV_ADDR
		|=> {sp_drv_gain, sp_unmute} == $past(reg_wdata[4:2])) else $error("sp driver");
	ctl_hold_a: assert property (!(hp_w || sp_w) |=> $stable({hp_route_en,
		hp_atten, hp_drv_gain, hp_unmute, hp_pd_hiz, sp_route_en, sp_atten,
		sp_drv_gain, sp_unmute})) else $error("control changed");
	hp_settle_a: assert property (hp_gain_applied == (hp_cnt >= ODG_SETTLE_CYCLES))
		else $error("hp applied flag");
	sp_settle_a: assert property (sp_gain_applied == (sp_cnt >= ODG_SETTLE_CYCLES))
		else $error("sp applied flag");
	hp_read_a: assert property (hp_drv_rd |=> reg_rdata[6:1] ==
		$past({hp_drv_gain, hp_unmute, hp_pd_hiz})) else $error("hp readback");
	rsvd_read_a: assert property (reg_rd && reg_addr == ODG_HP_VOL_RSVD_ADDR
		|=> reg_rdata == ODG_VOL_RSVD_RST) else $error("reserved readback");
endmodule : odg_checker
bind odg_output_driver_gain_regs odg_checker odg_checker_i (.mclk(mclk),
	.rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
	.hp_route_en(hp_route_en), .hp_atten(hp_atten),
	.hp_drv_gain(hp_drv_gain), .hp_unmute(hp_unmute),
	.hp_pd_hiz(hp_pd_hiz), .hp_gain_applied(hp_gain_applied),
	.sp_route_en(sp_route_en), .sp_atten(sp_atten),
	.sp_drv_gain(sp_drv_gain), .sp_unmute(sp_unmute),
	.sp_gain_applied(sp_gain_applied));

// file: verification/odg_host.sv
`timescale 1ns/1ps
module odg_host
	import odg_pkg::*;
(
	input wire logic       mclk,
	input wire logic [7:0] reg_rdata,
	output logic           reg_wr,
	output logic           reg_rd,
	output logic     [7:0] reg_addr,
	output logic     [7:0] reg_wdata
);
	initial begin
		{reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h00000;
	end
	// Callers keep gain codes legal and zero reserved bits
	// Common-mode power down also needs a clear elsewhere
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		{reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
		@(negedge mclk);
		reg_wr = 1'b0;
		@(negedge mclk);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		{reg_rd, reg_addr} = {1'b1, a};
		@(negedge mclk);
		reg_rd = 1'b0;
		d = reg_rdata;
		@(negedge mclk);
	endtask : rd
endmodule : odg_host

// file: verification/odg_output_driver_gain_regs_tb.sv
`timescale 1ns/1ps
module odg_output_driver_gain_regs_tb
	import odg_pkg::*;
;
	logic mclk = 1'b0, rst_n = 1'b0, reg_wr, reg_rd;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
	logic hp_route_en, hp_unmute, hp_pd_hiz, hp_gain_applied;
	logic sp_route_en, sp_unmute, sp_gain_applied;
	logic [6:0] hp_atten, sp_atten;
	logic [3:0] hp_drv_gain;
	logic [1:0] sp_drv_gain;
	int fail_count = 0, cmp_count = 0;
	logic [7:0] ra [6] = '{8'h24, 8'h25, 8'h26, 8'h28, 8'h29, 8'h2A};
	logic [7:0] re [6] = '{8'h7F, 8'h7F, 8'h7F, 8'h03, 8'h00, 8'h01};
	always #20 mclk = ~mclk;
	odg_output_driver_gain_regs odg_output_driver_gain_regs_i (.mclk(mclk),
		.rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.hp_route_en(hp_route_en), .hp_atten(hp_atten),
		.hp_drv_gain(hp_drv_gain), .hp_unmute(hp_unmute),
		.hp_pd_hiz(hp_pd_hiz), .hp_gain_applied(hp_gain_applied),
		.sp_route_en(sp_route_en), .sp_atten(sp_atten),
		.sp_drv_gain(sp_drv_gain), .sp_unmute(sp_unmute),
		.sp_gain_applied(sp_gain_applied));
	odg_host odg_host_i (.mclk(mclk), .reg_rdata(reg_rdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
	task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
		cmp_count++;
		if (s !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask : check
	task automatic complete_run();
		$display("checks %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : complete_run
	initial begin
		repeat (6) @(negedge mclk);
		rst_n = 1'b1;
		foreach (ra[i]) begin
			odg_host_i.rd(ra[i], d);
			check("reset read", d, re[i]);
		end
		$display("test reset done");
		odg_host_i.wr(ODG_HP_VOL_ADDR, 8'h85);
		odg_host_i.wr(ODG_HP_DRV_ADDR, 8'h4C);
		check("hp vol", {hp_route_en, hp_atten}, 8'h85);
		check("hp drv", 8'({hp_drv_gain, hp_unmute, hp_pd_hiz}), 8'h26);
		check("hp flag", 8'(hp_gain_applied), 8'h00);
		repeat (23) @(negedge mclk);
		check("hp flag", 8'(hp_gain_applied), 8'h00);
		@(negedge mclk);
		check("hp flag", 8'(hp_gain_applied), 8'h01);
		odg_host_i.rd(ODG_HP_DRV_ADDR, d);
		check("hp read", d, 8'h4D);
		$display("test headphone done");
		for (int c = 0; c < 4; c++) begin
			odg_host_i.wr(ODG_SP_DRV_ADDR, 8'({c[1:0], 3'h4}));
			check("sp gain", 8'({sp_drv_gain, sp_unmute}), 8'({c[1:0], 1'b1}));
		end
		// Reserved registers are never written by the host
		odg_host_i.wr(ODG_SP_VOL_ADDR, 8'h80);
		check("sp vol", {sp_route_en, sp_atten}, 8'h80);
		repeat (23) @(negedge mclk);
		check("sp flag", 8'(sp_gain_applied), 8'h00);
		@(negedge mclk);
		check("sp flag", 8'(sp_gain_applied), 8'h01);
		odg_host_i.rd(ODG_SP_VOL_RSVD_ADDR, d);
		check("rsvd read", d, 8'h7F);
		odg_host_i.rd(ODG_SP_DRV_ADDR, d);
		check("sp read", d, 8'h1D);
		$display("test speaker done");
		for (int c = 0; c <= int'(ODG_HP_GAIN_MAX); c++) begin
			odg_host_i.wr(ODG_HP_DRV_ADDR, 8'({c[3:0], 3'h2}));
			check("hp gain", 8'({hp_drv_gain, hp_unmute, hp_pd_hiz}), 8'({c[3:0], 2'h1}));
		end
		$display("test gain codes done");
		complete_run();
	end
	initial begin
		repeat (2000) @(posedge mclk);
		fail_count++;
		complete_run();
	end
endmodule : odg_output_driver_gain_regs_tb
